// ===== rtl/eet_top.sv
// EEPROM array with timebase divider, divider lock and AXI4-Lite registers.
// Assumes nrst is the system reset and por_n a power-on reset that only
// models the erased state of nonvolatile cells.
`timescale 1ns/1ps

module eet_top #(
  parameter int CYCLE_TICKS = 286,
  parameter int AXI_AW      = 18
) (
  // Clocks and resets.
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              por_n,
  // Reference and low-power inputs.
  input  wire logic              crystal_ref_clock,
  input  wire logic              stop_mode,
  // High-voltage state.
  output logic                   hv_on,
  // AXI4-Lite write address and data.
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // True when a register index falls inside the array window.
  function automatic logic in_array(input logic [15:0] idx);
    in_array = (idx >= eet_pkg::IDX_ARRAY_FIRST) && (idx <= eet_pkg::IDX_ARRAY_LAST);
  endfunction

  eet_tb_if tb ();

  eet_timebase #(
    .CYCLE_TICKS (CYCLE_TICKS)
  ) u_timebase (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .tb      (tb.timebase)
  );

  ////////////////////////////////////////////////////////////////////////
  // Nonvolatile storage: survives nrst, erased by power-on or by an erase cycle.
  logic [7:0] mem_q [eet_pkg::ARRAY_BYTES];
  logic [7:0] div_hi_nv_q;
  logic [7:0] div_lo_nv_q;
  logic [7:0] cfg_nv_q;

  // Volatile registers and sequence state.
  logic [7:0]  div_hi_q,   div_hi_d;
  logic [7:0]  div_lo_q,   div_lo_d;
  logic [7:0]  cfg_q,      cfg_d;
  logic [7:0]  ctrl_q,     ctrl_d;
  logic        clk_sel_q,  clk_sel_d;
  logic        load_q,     load_d;
  logic [15:0] lat_idx_q,  lat_idx_d;
  logic [7:0]  lat_dat_q,  lat_dat_d;
  logic        lat_vld_q,  lat_vld_d;
  logic        seq_done_q, seq_done_d;
  logic        held_q,     held_d;
  logic        stop_q,     stop_d;

  // Bus state.
  logic [15:0] aw_idx_q,   aw_idx_d;
  logic        aw_got_q,   aw_got_d;
  logic [7:0]  w_dat_q,    w_dat_d;
  logic        w_got_q,    w_got_d;
  logic        bvalid_q,   bvalid_d;
  logic [1:0]  bresp_q,    bresp_d;
  logic        rvalid_q,   rvalid_d;
  logic [1:0]  rresp_q,    rresp_d;
  logic [31:0] rdata_q,    rdata_d;

  logic        wr_fire;
  logic        fire;
  logic        locked;
  logic        lat;
  logic        pgm;
  logic [15:0] ar_idx;
  logic [7:0]  rd_byte;
  logic        rd_ok;
  logic [7:0]  wb;
  eet_pkg::eet_mode_t mode;

  assign lat    = ctrl_q[eet_pkg::CTRL_LAT];
  assign pgm    = ctrl_q[eet_pkg::CTRL_PGM];
  assign locked = ~div_hi_q[eet_pkg::HI_LOCK_BIT];
  assign mode   = eet_pkg::eet_mode_t'(ctrl_q[eet_pkg::CTRL_RAS_HI:eet_pkg::CTRL_RAS_LO]);
  assign ar_idx = 16'(s_axi_araddr >> 2);
  assign wb     = w_dat_q;

  // Timebase hookup; wait mode has no input here, so the timer never pauses for it.
  assign tb.divisor  = {div_hi_q[2:0], div_lo_q};
  assign tb.ref_sel  = clk_sel_q;
  assign tb.xtal_ref = crystal_ref_clock;
  assign tb.run      = pgm & lat & lat_vld_q & ~seq_done_q;
  assign tb.hold     = stop_mode;
  assign fire        = tb.done;

  // High voltage only while a sequence runs outside stop and power-down.
  assign hv_on = tb.run & ~stop_mode & ~ctrl_q[eet_pkg::CTRL_OFF];

  ////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order.
  assign s_axi_awready = ~aw_got_q & ~bvalid_q;
  assign s_axi_wready  = ~w_got_q & ~bvalid_q;
  assign wr_fire       = aw_got_q & w_got_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // Register next state; the timer end pulse wins over a software write.
  always_comb begin
    aw_idx_d   = aw_idx_q;
    aw_got_d   = aw_got_q;
    w_dat_d    = w_dat_q;
    w_got_d    = w_got_q;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    div_hi_d   = div_hi_q;
    div_lo_d   = div_lo_q;
    cfg_d      = cfg_q;
    ctrl_d     = ctrl_q;
    clk_sel_d  = clk_sel_q;
    load_d     = 1'b0;
    lat_idx_d  = lat_idx_q;
    lat_dat_d  = lat_dat_q;
    lat_vld_d  = lat_vld_q;
    seq_done_d = seq_done_q;
    held_d     = held_q;
    stop_d     = stop_mode;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_idx_d = 16'(s_axi_awaddr >> 2);
      aw_got_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_dat_d = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      w_got_d = s_axi_wstrb[0];
      if (!s_axi_wstrb[0]) begin
        w_got_d = 1'b1;
      end
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = eet_pkg::RESP_OKAY;
      case (aw_idx_q)
        eet_pkg::IDX_DIV_HI: begin
          if (!locked) begin
            div_hi_d[eet_pkg::HI_LOCK_BIT] = wb[eet_pkg::HI_LOCK_BIT];
            if (!lat) begin
              div_hi_d[2:0] = wb[2:0];
            end
          end
        end
        eet_pkg::IDX_DIV_LO: begin
          if (!locked && !lat) begin
            div_lo_d = wb;
          end
        end
        eet_pkg::IDX_CTRL: begin
          ctrl_d = wb & 8'hbf;
          // Power can only rise on a latched valid target.
          if (!(lat && lat_vld_q)) begin
            ctrl_d[eet_pkg::CTRL_PGM] = 1'b0;
          end
          // Latch stays while power is on, so the high voltage can drain.
          if (pgm) begin
            ctrl_d[eet_pkg::CTRL_LAT] = 1'b1;
          end
          if (!ctrl_d[eet_pkg::CTRL_PGM]) begin
            seq_done_d = 1'b0;
            held_d     = 1'b0;
          end
          if (!ctrl_d[eet_pkg::CTRL_LAT]) begin
            lat_vld_d = 1'b0;
          end
        end
        eet_pkg::IDX_CLK_SEL: begin
          clk_sel_d = wb[0];
        end
        eet_pkg::IDX_DIV_HI_NV, eet_pkg::IDX_DIV_LO_NV, eet_pkg::IDX_CFG_NV: begin
          // Nonvolatile bytes take writes only as latched program targets.
          if (lat && !pgm && !(locked && aw_idx_q != eet_pkg::IDX_CFG_NV)) begin
            lat_idx_d = aw_idx_q;
            lat_dat_d = wb;
            lat_vld_d = 1'b1;
          end
        end
        default: begin
          if (in_array(aw_idx_q)) begin
            if (lat && !pgm) begin
              lat_idx_d = aw_idx_q;
              lat_dat_d = wb;
              lat_vld_d = 1'b1;
            end else if (held_q) begin
              bresp_d = eet_pkg::RESP_SLVERR;
            end
          end else if (aw_idx_q != eet_pkg::IDX_CFG && aw_idx_q != eet_pkg::IDX_STATUS) begin
            bresp_d = eet_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
    // Stop entry: hold a powered sequence, abort an unpowered latch.
    if (stop_mode && !stop_q && lat) begin
      if (pgm) begin
        held_d = 1'b1;
      end else begin
        ctrl_d[eet_pkg::CTRL_LAT] = 1'b0;
        lat_vld_d                 = 1'b0;
      end
    end
    if (fire) begin
      seq_done_d = 1'b1;
      held_d     = 1'b0;
      if (ctrl_q[eet_pkg::CTRL_AUTO]) begin
        ctrl_d[eet_pkg::CTRL_PGM] = 1'b0;
        seq_done_d                = 1'b0;
      end
    end
    // One cycle after reset the volatile copies are loaded.
    if (load_q) begin
      div_hi_d = {div_hi_nv_q[7], 4'h0, div_hi_nv_q[2:0]};
      div_lo_d = div_lo_nv_q;
      cfg_d    = cfg_nv_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel: one cycle from address to data.
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  always_comb begin
    rd_ok   = 1'b1;
    rd_byte = 8'h00;
    case (ar_idx)
      eet_pkg::IDX_DIV_HI_NV: rd_byte = div_hi_nv_q;
      eet_pkg::IDX_DIV_LO_NV: rd_byte = div_lo_nv_q;
      eet_pkg::IDX_DIV_HI:    rd_byte = div_hi_q & 8'h87;
      eet_pkg::IDX_DIV_LO:    rd_byte = div_lo_q;
      eet_pkg::IDX_CFG_NV:    rd_byte = cfg_nv_q;
      eet_pkg::IDX_CTRL:      rd_byte = ctrl_q;
      eet_pkg::IDX_CFG:       rd_byte = cfg_q;
      eet_pkg::IDX_CLK_SEL:   rd_byte = {7'h00, clk_sel_q};
      eet_pkg::IDX_STATUS: begin
        rd_byte[eet_pkg::ST_HV]     = hv_on;
        rd_byte[eet_pkg::ST_HELD]   = held_q;
        rd_byte[eet_pkg::ST_LOCKED] = locked;
        rd_byte[eet_pkg::ST_DONE]   = seq_done_q;
      end
      default: begin
        if (in_array(ar_idx) && !held_q) begin
          rd_byte = mem_q[ar_idx[eet_pkg::ADDR_BITS-1:0]];
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d  = {24'h000000, rd_byte};
      rresp_d  = rd_ok ? eet_pkg::RESP_OKAY : eet_pkg::RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Volatile and bus registers.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_hi_q   <= 8'h00;
      div_lo_q   <= 8'h00;
      cfg_q      <= 8'h00;
      ctrl_q     <= eet_pkg::CTRL_RESET;
      clk_sel_q  <= 1'b0;
      load_q     <= 1'b1;
      lat_idx_q  <= 16'h0000;
      lat_dat_q  <= 8'h00;
      lat_vld_q  <= 1'b0;
      seq_done_q <= 1'b0;
      held_q     <= 1'b0;
      stop_q     <= 1'b0;
      aw_idx_q   <= 16'h0000;
      aw_got_q   <= 1'b0;
      w_dat_q    <= 8'h00;
      w_got_q    <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= eet_pkg::RESP_OKAY;
      rvalid_q   <= 1'b0;
      rresp_q    <= eet_pkg::RESP_OKAY;
      rdata_q    <= 32'h00000000;
    end else begin
      div_hi_q   <= div_hi_d;
      div_lo_q   <= div_lo_d;
      cfg_q      <= cfg_d;
      ctrl_q     <= ctrl_d;
      clk_sel_q  <= clk_sel_d;
      load_q     <= load_d;
      lat_idx_q  <= lat_idx_d;
      lat_dat_q  <= lat_dat_d;
      lat_vld_q  <= lat_vld_d;
      seq_done_q <= seq_done_d;
      held_q     <= held_d;
      stop_q     <= stop_d;
      aw_idx_q   <= aw_idx_d;
      aw_got_q   <= aw_got_d;
      w_dat_q    <= w_dat_d;
      w_got_q    <= w_got_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      rvalid_q   <= rvalid_d;
      rresp_q    <= rresp_d;
      rdata_q    <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Nonvolatile cells change only at power-on or when a timed cycle ends. Programming can
  // only clear bits, erasing sets a byte, block or the whole array.
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      for (int i = 0; i < eet_pkg::ARRAY_BYTES; i++) begin
        mem_q[i] <= eet_pkg::ERASED;
      end
      div_hi_nv_q <= eet_pkg::ERASED;
      div_lo_nv_q <= eet_pkg::ERASED;
      cfg_nv_q    <= eet_pkg::ERASED;
    end else if (fire) begin
      if (in_array(lat_idx_q)) begin
        for (int i = 0; i < eet_pkg::ARRAY_BYTES; i++) begin
          if (mode == eet_pkg::EET_BULK_ERASE ||
              (mode == eet_pkg::EET_BLOCK_ERASE &&
               2'(i >> eet_pkg::BLOCK_LSB) ==
               lat_idx_q[eet_pkg::BLOCK_MSB:eet_pkg::BLOCK_LSB])) begin
            mem_q[i] <= eet_pkg::ERASED;
          end
        end
        if (mode == eet_pkg::EET_BYTE_ERASE) begin
          mem_q[lat_idx_q[eet_pkg::ADDR_BITS-1:0]] <= eet_pkg::ERASED;
        end else if (mode == eet_pkg::EET_BYTE_PROGRAM) begin
          mem_q[lat_idx_q[eet_pkg::ADDR_BITS-1:0]] <=
            mem_q[lat_idx_q[eet_pkg::ADDR_BITS-1:0]] & lat_dat_q;
        end
      end else if (lat_idx_q == eet_pkg::IDX_DIV_HI_NV && !locked) begin
        div_hi_nv_q <= (mode == eet_pkg::EET_BYTE_PROGRAM) ? (div_hi_nv_q & lat_dat_q)
                                                           : eet_pkg::ERASED;
      end else if (lat_idx_q == eet_pkg::IDX_DIV_LO_NV && !locked) begin
        div_lo_nv_q <= (mode == eet_pkg::EET_BYTE_PROGRAM) ? (div_lo_nv_q & lat_dat_q)
                                                           : eet_pkg::ERASED;
      end else if (lat_idx_q == eet_pkg::IDX_CFG_NV) begin
        cfg_nv_q <= (mode == eet_pkg::EET_BYTE_PROGRAM) ? (cfg_nv_q & lat_dat_q)
                                                        : eet_pkg::ERASED;
      end
    end
  end

endmodule

// ===== rtl/eet_pkg.sv
// Shared constants for the EEPROM timebase divider and lock block.
// Assumes a 32-bit AXI4-Lite register bus, one register per aligned word.
package eet_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_DIV_HI_NV   = 16'hff70;
  localparam logic [15:0] IDX_DIV_LO_NV   = 16'hff71;
  localparam logic [15:0] IDX_DIV_HI      = 16'hff7a;
  localparam logic [15:0] IDX_DIV_LO      = 16'hff7b;
  localparam logic [15:0] IDX_CFG_NV      = 16'hff7c;
  localparam logic [15:0] IDX_CTRL        = 16'hff7d;
  localparam logic [15:0] IDX_CFG         = 16'hff7f;
  localparam logic [15:0] IDX_CLK_SEL     = 16'hff80;
  localparam logic [15:0] IDX_STATUS      = 16'hff81;
  localparam logic [15:0] IDX_ARRAY_FIRST = 16'h0600;
  localparam logic [15:0] IDX_ARRAY_LAST  = 16'h07ff;

  // Array geometry.
  localparam int ARRAY_BYTES = 512;
  localparam int ADDR_BITS   = 9;
  localparam int BLOCK_MSB   = 8;
  localparam int BLOCK_LSB   = 7;

  // Divider high register layout.
  localparam int HI_LOCK_BIT = 7;
  localparam int DIV_WIDTH   = 11;

  // Control register layout.
  localparam int CTRL_UNUSED = 7;
  localparam int CTRL_OFF    = 5;
  localparam int CTRL_RAS_HI = 4;
  localparam int CTRL_RAS_LO = 3;
  localparam int CTRL_LAT    = 2;
  localparam int CTRL_AUTO   = 1;
  localparam int CTRL_PGM    = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register layout.
  localparam int ST_HV     = 0;
  localparam int ST_HELD   = 1;
  localparam int ST_LOCKED = 2;
  localparam int ST_DONE   = 3;

  // Erased nonvolatile byte.
  localparam logic [7:0] ERASED = 8'hff;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Program and erase mode field values.
  typedef enum logic [1:0] {
    EET_BYTE_PROGRAM,
    EET_BYTE_ERASE,
    EET_BLOCK_ERASE,
    EET_BULK_ERASE
  } eet_mode_t;

endpackage

// ===== rtl/eet_tb_if.sv
// Carrier between the register core and the timebase divider/timer.
// Assumes both ends run on the same ref_clk.
`timescale 1ns/1ps
interface eet_tb_if;
  logic [10:0] divisor;    // Programmed timebase divisor.
  logic        ref_sel;    // 1 selects the crystal reference, 0 the bus clock.
  logic        xtal_ref;   // Crystal-derived reference level.
  logic        run;        // Sequence timer enabled.
  logic        hold;       // Timer frozen, high voltage removed.
  logic        tick;       // One-cycle timebase pulse.
  logic        done;       // One-cycle pulse at end of the timed cycle.

  modport core (output divisor, output ref_sel, output xtal_ref, output run, output hold,
                input tick, input done);
  modport timebase (input divisor, input ref_sel, input xtal_ref, input run, input hold,
                    output tick, output done);
endinterface

// ===== rtl/eet_timebase.sv
// Timebase divider and program/erase cycle timer.
// Assumes the crystal reference level is synchronous to ref_clk.
`timescale 1ns/1ps
module eet_timebase #(
  parameter int CYCLE_TICKS = 286
) (
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic nrst,
  // Core side.
  eet_tb_if.timebase tb
);

  logic [10:0] div_cnt_q, div_cnt_d;
  logic [15:0] tmr_q,     tmr_d;
  logic        xtal_q,    xtal_d;
  logic        ref_evt;
  logic        tick_d;
  logic        done_d;
  logic        tick_q;
  logic        done_q;

  ////////////////////////////////////////////////////////////////////////
  // Divider: count reference events up to the divisor, one tick per period.
  always_comb begin
    xtal_d    = tb.xtal_ref;
    ref_evt   = tb.ref_sel ? (tb.xtal_ref & ~xtal_q) : 1'b1;
    div_cnt_d = div_cnt_q;
    tick_d    = 1'b0;
    if (ref_evt) begin
      // A divisor of zero behaves as one so the tick never stalls.
      if (div_cnt_q + 11'h001 >= tb.divisor) begin
        div_cnt_d = 11'h000;
        tick_d    = 1'b1;
      end else begin
        div_cnt_d = div_cnt_q + 11'h001;
      end
    end
  end

  // Timer: advances on ticks while running, frozen while held.
  always_comb begin
    tmr_d  = tmr_q;
    done_d = 1'b0;
    if (!tb.run) begin
      tmr_d = 16'h0000;
    end else if (!tb.hold && tick_q) begin
      if (tmr_q + 16'h0001 >= 16'(CYCLE_TICKS)) begin
        tmr_d  = 16'h0000;
        done_d = 1'b1;
      end else begin
        tmr_d = tmr_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_q <= 11'h000;
      tmr_q     <= 16'h0000;
      xtal_q    <= 1'b0;
      tick_q    <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      tmr_q     <= tmr_d;
      xtal_q    <= xtal_d;
      tick_q    <= tick_d;
      done_q    <= done_d;
    end
  end

  assign tb.tick = tick_q;
  assign tb.done = done_q;

endmodule

// ===== tb/eet_top_sva.sv
// Bus handshake and stop-mode checker for the EEPROM timebase block.
// Assumes it is bound to eet_top and sees only that module's ports.
`timescale 1ns/1ps
module eet_top_sva (
  // Clock, reset and low-power state.
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        stop_mode,
  input wire logic        hv_on,
  // Write channels.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channels.
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // All checks share ref_clk and rest while reset is held.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Both write channels taken on one edge, then captured, then answered.
  sequence wr_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer_s;
    (!s_axi_awready && !s_axi_wready) ##1 s_axi_bvalid;
  endsequence
  // A response must stand until the master takes it.
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response dropped early");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while response pending");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (wr_taken_s |=> wr_answer_s)
    else $error("write answer late");
  err_data_a: assert property (s_axi_rvalid && s_axi_rresp == eet_pkg::RESP_SLVERR |->
    s_axi_rdata == 32'h0)
    else $error("error read returned data");
  hv_stop_a: assert property (stop_mode |-> !hv_on)
    else $error("high voltage on in stop");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind eet_top eet_top_sva chk_u (
  .ref_clk(ref_clk), .nrst(nrst), .stop_mode(stop_mode), .hv_on(hv_on),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));

// ===== tb/eet_top_tb.sv
// Self-checking bench for the EEPROM timebase block over AXI4-Lite.
// Assumes eet_top with a short cycle timer and the bound checker.
`timescale 1ns/1ps
module eet_top_tb;
  // Clock, resets and side inputs.
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        por_n = 1'b0;
  logic        xclk = 1'b0;
  logic        stop = 1'b0;
  // Bus master signals.
  logic [17:0] awaddr = 18'h0;
  logic [17:0] araddr = 18'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  // Design outputs.
  logic        hv_on, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          error_cnt = 0;
  int          num_checks = 0;
  localparam logic [15:0] CT = eet_pkg::IDX_CTRL;
  localparam logic [15:0] ST = eet_pkg::IDX_STATUS;
  localparam logic [15:0] HI = eet_pkg::IDX_DIV_HI;
  localparam logic [15:0] LO = eet_pkg::IDX_DIV_LO;
  localparam logic [15:0] HN = eet_pkg::IDX_DIV_HI_NV;
  localparam logic [15:0] A0 = eet_pkg::IDX_ARRAY_FIRST;
  localparam logic [1:0]  OK = eet_pkg::RESP_OKAY;
  localparam logic [1:0]  ER = eet_pkg::RESP_SLVERR;

  eet_top #(.CYCLE_TICKS(3)) dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .por_n(por_n), .crystal_ref_clock(xclk), .stop_mode(stop),
    .hv_on(hv_on), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // Clock; the crystal reference runs at half rate, in step with ref_clk.
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) xclk <= ~xclk;
  ////////////////////////////////////////////////////////////////////////////
  // Comparisons of data words and of response codes.
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready is looked at mid-cycle, where it is settled, and acted on at the next edge.
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic a, w, na, nw;
    logic [1:0] r;
    a = 1'b0;
    w = 1'b0;
    @(posedge ref_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a && w)) begin
      @(negedge ref_clk);
      na = awready;
      nw = wready;
      @(posedge ref_clk);
      if (na && !a) begin
        awvalid <= 1'b0;
        a = 1'b1;
      end
      if (nw && !w) begin
        wvalid <= 1'b0;
        w = 1'b1;
      end
    end
    do @(negedge ref_clk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge ref_clk);
    bready <= 1'b0;
    chk_resp(r, OK);
  endtask
  task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge ref_clk); while (arready !== 1'b1);
    @(posedge ref_clk);
    arvalid <= 1'b0;
    do @(negedge ref_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge ref_clk);
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [15:0] idx, input logic [7:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk_data(d, {24'h0, e});
    chk_resp(r, er);
  endtask
  // Reads a register until one bit takes the wanted level; the watchdog bounds it.
  task automatic poll(input logic [15:0] idx, input int b, input logic v);
    logic [31:0] d;
    logic [1:0] r;
    do rd(idx, d, r); while (d[b] !== v);
  endtask
  // One automatic program or erase cycle in the given mode; stop stays low.
  task automatic prog(input logic [15:0] idx, input logic [7:0] d, input logic [7:0] m);
    wr(CT, m | 8'h04);
    wr(idx, d);
    wr(CT, m | 8'h07);
    poll(CT, 0, 1'b0);
    wr(CT, 8'h00);
  endtask
  task automatic pulse_reset();
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole run needs well under this many cycles.
  initial begin
    repeat (60000) @(posedge ref_clk);
    error_cnt++;
    conclude();
  end
  // Main sequence: power-on, then each behaviour in turn.
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rc(HI, 8'h87, OK);
    rc(LO, 8'hff, OK);
    rc(CT, 8'h00, OK);
    rc(eet_pkg::IDX_CFG, 8'hff, OK);
    rc(16'hff7e, 8'h00, ER);
    rc(eet_pkg::IDX_ARRAY_LAST, 8'hff, OK);
    rc(16'h0800, 8'h00, ER);
    wr(HI, 8'hff);
    rc(HI, 8'h87, OK);
    // Short divisor so each cycle ends quickly; set before any cycle.
    wr(HI, 8'h80);
    wr(LO, 8'h40);
    rc(LO, 8'h40, OK);
    wr(CT, 8'hc0);
    rc(CT, 8'h80, OK);
    wr(CT, 8'h04);
    wr(LO, 8'h33);
    rc(LO, 8'h40, OK);
    wr(CT, 8'h00);
    // Program held by stop, then resumed to completion.
    wr(CT, 8'h04);
    wr(A0, 8'h5a);
    wr(CT, 8'h05);
    rc(ST, 8'h01, OK);
    @(negedge ref_clk);
    chk_data(32'(hv_on), 32'h1);
    @(posedge ref_clk);
    stop <= 1'b1;
    rc(ST, 8'h02, OK);
    rc(A0, 8'h00, ER);
    @(negedge ref_clk);
    chk_data(32'(hv_on), 32'h0);
    @(posedge ref_clk);
    stop <= 1'b0;
    poll(ST, 3, 1'b1);
    rc(ST, 8'h08, OK);
    wr(CT, 8'h04);
    wr(CT, 8'h00);
    rc(A0, 8'h5a, OK);
    // Stop with the latch set and power off drops the sequence.
    wr(CT, 8'h04);
    wr(A0, 8'h00);
    @(posedge ref_clk);
    stop <= 1'b1;
    repeat (3) @(posedge ref_clk);
    stop <= 1'b0;
    rc(CT, 8'h00, OK);
    rc(A0, 8'h5a, OK);
    // Byte, block and bulk erase.
    prog(A0, 8'hff, 8'h08);
    rc(A0, 8'hff, OK);
    prog(A0 + 16'h0080, 8'h00, 8'h00);
    prog(A0 + 16'h0001, 8'h00, 8'h00);
    prog(A0, 8'h00, 8'h10);
    rc(A0 + 16'h0080, 8'h00, OK);
    rc(A0 + 16'h0001, 8'hff, OK);
    wr(eet_pkg::IDX_CLK_SEL, 8'h01);
    prog(A0, 8'h00, 8'h18);
    rc(A0 + 16'h0080, 8'hff, OK);
    // Arm the divider lock through its nonvolatile copy.
    prog(HN, 8'h01, 8'h00);
    rc(HN, 8'h01, OK);
    pulse_reset();
    rc(HI, 8'h01, OK);
    rc(LO, 8'hff, OK);
    rc(ST, 8'h04, OK);
    wr(HI, 8'h80);
    wr(LO, 8'h12);
    rc(HI, 8'h01, OK);
    rc(LO, 8'hff, OK);
    prog(HN, 8'hff, 8'h08);
    rc(HN, 8'h01, OK);
    conclude();
  end
endmodule
